// >>> eism_ctrl.v
// Summary of operation
// - Sense bit: 0 low level, 1 falling edge
// - Per-line enable bit, reset 0
// - Enabled falling edge latches pending request
// - Disable keeps pending, blocks new edges
// - Mask, sense 0, enable 0 clear pending
// - Two key mask registers cover sixteen keys
// - Key mask 0 enables, 1 blocks
// - Key masks reset ones except low bit 6
// - Unmasked keys ORed into line six
// - Nonmask request ignores global mask
// - Nonmask vector 3, sets global mask
// - Lines 0..7 vectors 4..11, 0 highest
// - Global mask blocks all maskable lines
// - Accepting maskable request sets global mask
// - Nonmask, lines 0,1,2,6 wake standby
// - Detection uses pin level regardless direction
// - Nonmask edge select: 0 falling, 1 rising
`include "eism_defines.vh"

module eism_ctrl #(
  parameter LINES = 8,
  parameter KEYS  = 16
) (
  input  wire              CORE_CLK,
  input  wire              RST_B,
  input  wire              PSEL,
  input  wire              PENABLE,
  input  wire              PWRITE,
  input  wire [7:0]        PADDR,
  input  wire [31:0]       PWDATA,
  output reg  [31:0]       PRDATA,
  output wire              PREADY,
  output reg               PSLVERR,
  input  wire [LINES-1:0]  IRQ_PIN_B,
  input  wire [KEYS-1:0]   KEY_SENSE_B,
  input  wire              NMI_PIN_B,
  input  wire              CPU_MASK,
  input  wire              VEC_TAKE,
  output reg               INT_REQ,
  output reg  [5:0]        INT_VECTOR,
  output wire              MASK_SET,
  output reg               WAKE
);

  localparam NPIN = LINES + KEYS + 1;

  reg  [7:0]       ext_sense_select;
  reg  [7:0]       ext_request_enable;
  reg  [7:0]       key_mask_low;
  reg  [7:0]       key_mask_high;
  reg              nonmask_edge_select;
  reg  [NPIN-1:0]  sync1;
  reg  [NPIN-1:0]  sync2;
  reg  [NPIN-1:0]  sync3;
  reg  [NPIN-1:0]  pin_lvl;
  reg  [NPIN-1:0]  pin_prev;
  reg  [LINES-1:0] edge_pend;
  reg              nmi_pend;
  reg  [5:0]       next_vector;
  reg              next_req;
  reg  [31:0]      rd_mux;
  reg              rd_err;
  wire [NPIN-1:0]  pins_in;
  wire [KEYS-1:0]  key_active;
  wire [LINES-1:0] line_active;
  reg  [LINES-1:0] line_prev;
  wire [LINES-1:0] line_fall;
  wire [LINES-1:0] level_req;
  wire [LINES-1:0] line_req;
  wire [LINES-1:0] accepted;
  wire             nmi_lvl;
  wire             nmi_prev;
  wire             nmi_edge;
  wire             wr_en;
  wire             setup;
  wire             take_nmi;

  // Pins are active low; line and key sensing below works on active-high copies, nonmask edge detect on the raw pin level
  assign pins_in = {NMI_PIN_B, KEY_SENSE_B, IRQ_PIN_B};

  // Three-stage synchroniser; a change counts once stages two and three agree
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync1    <= {NPIN{1'b1}};
      sync2    <= {NPIN{1'b1}};
      sync3    <= {NPIN{1'b1}};
      pin_lvl  <= {NPIN{1'b1}};
      pin_prev <= {NPIN{1'b1}};
    end else begin
      sync1    <= pins_in;
      sync2    <= sync1;
      sync3    <= sync2;
      pin_lvl  <= (sync2 & sync3) | (pin_lvl & (sync2 | sync3));
      pin_prev <= pin_lvl;
    end
  end

  // Key inputs masked and merged into line six
  assign key_active = ~pin_lvl[LINES +: KEYS] & ~{key_mask_high, key_mask_low};

  assign line_active = ~pin_lvl[LINES-1:0] | ({LINES{|key_active}} & 8'h40);
  assign line_fall   = line_active & ~line_prev;

  // Previous merged level, so a held key does not fake an edge on line six
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      line_prev <= {LINES{1'b0}};
    end else begin
      line_prev <= line_active;
    end
  end

  // Level sensing follows the pin, nothing latched
  assign level_req = line_active & ext_request_enable & ~ext_sense_select;
  assign line_req  = level_req | edge_pend;
  assign accepted  = line_req & {LINES{~CPU_MASK}};

  assign nmi_lvl  = pin_lvl[NPIN-1];
  assign nmi_prev = pin_prev[NPIN-1];
  // Falling edge when select is 0, rising when 1
  assign nmi_edge = nonmask_edge_select ? (nmi_lvl & ~nmi_prev)
                                        : (~nmi_lvl & nmi_prev);

  assign take_nmi = VEC_TAKE & INT_REQ & (INT_VECTOR == `EISM_VEC_NMI);

  genvar g;
  generate
    for (g = 0; g < LINES; g = g + 1) begin : g_line
      wire set_p;
      wire clr_p;
      // New edges need the enable; a latched one survives disable
      assign set_p = line_fall[g] & ext_sense_select[g] & ext_request_enable[g];
      assign clr_p = (CPU_MASK & ~ext_sense_select[g] & ~ext_request_enable[g])
                   | (VEC_TAKE & INT_REQ
                      & (INT_VECTOR == `EISM_VEC_LINE0 + g));
      always @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
          edge_pend[g] <= 1'b0;
        end else if (set_p) begin
          // Set wins so a coincident edge is not lost
          edge_pend[g] <= 1'b1;
        end else if (clr_p) begin
          edge_pend[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Nonmask latch never looks at the global mask
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      nmi_pend <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend <= 1'b1;
    end else if (take_nmi) begin
      nmi_pend <= 1'b0;
    end
  end

  // Fixed priority: nonmask first, then line 0 down to line 7
  integer i;
  always @* begin
    next_req    = 1'b0;
    next_vector = 6'h00;
    for (i = LINES - 1; i >= 0; i = i - 1) begin
      if (accepted[i]) begin
        next_req    = 1'b1;
        next_vector = `EISM_VEC_LINE0 + i[5:0];
      end
    end
    if (nmi_pend) begin
      next_req    = 1'b1;
      next_vector = `EISM_VEC_NMI;
    end
  end

  // Vector stays registered; a take just after it went stale clears nothing
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      INT_REQ    <= 1'b0;
      INT_VECTOR <= 6'h00;
      WAKE       <= 1'b0;
    end else begin
      INT_REQ    <= next_req & ~(VEC_TAKE & INT_REQ);
      INT_VECTOR <= next_vector;
      WAKE       <= nmi_pend | |(line_req & `EISM_WAKE_LINES);
    end
  end

  // Every taken vector, nonmask or maskable, sets the global mask
  assign MASK_SET = VEC_TAKE & INT_REQ;

  // APB slave, zero wait states
  assign PREADY = 1'b1;
  assign setup  = PSEL & ~PENABLE;
  assign wr_en  = PSEL & PENABLE & PWRITE;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (PADDR)
      `EISM_OFS_SENSE:    rd_mux[7:0] = ext_sense_select;
      `EISM_OFS_ENABLE:   rd_mux[7:0] = ext_request_enable;
      `EISM_OFS_KEY_LOW:  rd_mux[7:0] = key_mask_low;
      `EISM_OFS_KEY_HIGH: rd_mux[7:0] = key_mask_high;
      `EISM_OFS_SYSCTL:   rd_mux[`EISM_SYSCTL_EDGE] = nonmask_edge_select;
      `EISM_OFS_STATUS: begin
        rd_mux[7:0]             = edge_pend;
        rd_mux[`EISM_STATUS_NMI] = nmi_pend;
      end
      default:            rd_err = 1'b1;
    endcase
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
      PSLVERR <= rd_err;
    end
  end

  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ext_sense_select    <= `EISM_RST_SENSE;
      ext_request_enable  <= `EISM_RST_ENABLE;
      key_mask_low        <= `EISM_RST_KEY_LOW;
      key_mask_high       <= `EISM_RST_KEY_HIGH;
      nonmask_edge_select <= `EISM_RST_SYSCTL;
    end else if (wr_en) begin
      case (PADDR)
        `EISM_OFS_SENSE:    ext_sense_select    <= PWDATA[7:0];
        `EISM_OFS_ENABLE:   ext_request_enable  <= PWDATA[7:0];
        `EISM_OFS_KEY_LOW:  key_mask_low        <= PWDATA[7:0];
        `EISM_OFS_KEY_HIGH: key_mask_high       <= PWDATA[7:0];
        `EISM_OFS_SYSCTL:   nonmask_edge_select <= PWDATA[`EISM_SYSCTL_EDGE];
        default:            ext_sense_select    <= ext_sense_select;
      endcase
    end
  end

endmodule

// >>> eism_ctrl_bench.sv
module eism_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        CORE_CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic        CPU_MASK = 1'b0, VEC_TAKE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000, rd;
  wire  [31:0] PRDATA;
  wire  [5:0]  INT_VECTOR;
  wire  [7:0]  IRQ_PIN_B;
  wire  [15:0] KEY_SENSE_B;
  wire         PREADY, PSLVERR, INT_REQ, MASK_SET, WAKE, NMI_PIN_B;
  int          errors = 0, n_tests = 0;
  always #20 CORE_CLK = ~CORE_CLK;
  eism_ctrl DUT (.CORE_CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .IRQ_PIN_B, .KEY_SENSE_B, .NMI_PIN_B, .CPU_MASK, .VEC_TAKE, .INT_REQ, .INT_VECTOR,
    .MASK_SET, .WAKE);
  eism_pins PINS (.IRQ_PIN_B, .KEY_SENSE_B, .NMI_PIN_B);
  task automatic chk(input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do @(posedge CORE_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic pins(input logic [7:0] irq, input logic [15:0] key, input logic nmi);
    @(posedge CORE_CLK);
    PINS.IRQ_PIN_B <= irq;
    PINS.KEY_SENSE_B <= key;
    PINS.NMI_PIN_B <= nmi;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge CORE_CLK);
  endtask
  task automatic mask(input logic m);
    @(posedge CORE_CLK);
    CPU_MASK <= m;
  endtask
  task automatic wait_req(input logic [5:0] v);
    repeat (20) if (INT_REQ !== 1'b1) @(negedge CORE_CLK);
    chk({1'b1, v}, {INT_REQ, INT_VECTOR});
  endtask
  task automatic take;
    @(posedge CORE_CLK);
    VEC_TAKE <= 1'b1;
    cyc(1);
    chk(1'b1, MASK_SET);
    @(posedge CORE_CLK);
    VEC_TAKE <= 1'b0;
    cyc(1);
    chk(1'b0, INT_REQ);
  endtask
  task automatic t_regs;
    logic [31:0] tab [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_00BF, 32'h0000_00FF, 32'h0};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(tab[i], rd);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(1'b1, PSLVERR);
  endtask
  task automatic t_level;
    apb(1'b1, 8'h04, 32'h0000_0008);
    pins(8'hF7, 16'hFFFF, 1'b1);
    wait_req(6'h07);
    mask(1'b1);
    cyc(3);
    chk(1'b0, INT_REQ);
    pins(8'hFF, 16'hFFFF, 1'b1);
    mask(1'b0);
    cyc(10);
    chk(1'b0, INT_REQ);
    apb(1'b1, 8'h04, 32'h0);
  endtask
  task automatic t_edge;
    apb(1'b1, 8'h00, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_0001);
    for (int k = 0; k < 2; k++) begin
      pins(8'hFE, 16'hFFFF, 1'b1);
      cyc(4);
      pins(8'hFF, 16'hFFFF, 1'b1);
      if (k == 0) wait_req(6'h04);
      if (k == 0) chk(1'b1, WAKE);
      if (k == 0) take;
      mask(1'b1);
    end
    cyc(8);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'h0000_0001, rd);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h00, 32'h0000_0001);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'h0, rd);
    mask(1'b0);
  endtask
  task automatic t_key;
    apb(1'b1, 8'h04, 32'h0000_0040);
    apb(1'b1, 8'h08, 32'h0000_00FF);
    apb(1'b1, 8'h0C, 32'h0000_00FE);
    pins(8'hFF, 16'hFFFE, 1'b1);
    cyc(12);
    chk(1'b0, INT_REQ);
    pins(8'hFF, 16'hFEFF, 1'b1);
    wait_req(6'h0A);
    pins(8'hFF, 16'hFFFF, 1'b1);
    apb(1'b1, 8'h04, 32'h0);
  endtask
  task automatic t_nmi;
    mask(1'b1);
    apb(1'b1, 8'h10, 32'h0000_0001);
    pins(8'hFF, 16'hFFFF, 1'b0);
    cyc(12);
    chk(1'b0, INT_REQ);
    pins(8'hFF, 16'hFFFF, 1'b1);
    wait_req(6'h03);
    chk(1'b1, WAKE);
    take;
    mask(1'b0);
  endtask
  task automatic complete_run;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge CORE_CLK);
    errors++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    t_regs;
    t_level;
    t_edge;
    t_key;
    t_nmi;
    complete_run;
  end
endmodule
bind eism_ctrl eism_ctrl_sva SVA (.CORE_CLK, .RST_B, .PRDATA, .PREADY, .PSLVERR, .CPU_MASK,
  .VEC_TAKE, .INT_REQ, .INT_VECTOR, .MASK_SET, .WAKE);

// >>> eism_ctrl_sva.sv
module eism_ctrl_sva (
  input wire        CORE_CLK,
  input wire        RST_B,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire        CPU_MASK,
  input wire        VEC_TAKE,
  input wire        INT_REQ,
  input wire [5:0]  INT_VECTOR,
  input wire        MASK_SET,
  input wire        WAKE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_take; VEC_TAKE && INT_REQ; endsequence
  sequence s_nmi; INT_REQ && INT_VECTOR == 6'h03; endsequence
  property p_take_mask; MASK_SET == (VEC_TAKE && INT_REQ); endproperty
  property p_take_drop; s_take |=> !INT_REQ; endproperty
  property p_vec_range; INT_REQ |-> INT_VECTOR >= 6'h03 && INT_VECTOR <= 6'h0B; endproperty
  // Two masked cycles so the registered request has caught up
  property p_masked; $past(CPU_MASK) && $past(CPU_MASK, 2) && INT_REQ |-> s_nmi; endproperty
  property p_nmi_hold; s_nmi and !VEC_TAKE |=> s_nmi; endproperty
  property p_wake; s_nmi |-> WAKE; endproperty
  property p_ready; PREADY; endproperty
  property p_err; PSLVERR |-> PRDATA == 32'h0000_0000; endproperty
  a_take_mask: assert property (p_take_mask) else $error("mask pulse wrong");
  a_take_drop: assert property (p_take_drop) else $error("request kept after take");
  a_vec_range: assert property (p_vec_range) else $error("vector out of range");
  a_masked: assert property (p_masked) else $error("maskable request while masked");
  a_nmi_hold: assert property (p_nmi_hold) else $error("nonmask request lost");
  a_wake: assert property (p_wake) else $error("no wake on nonmask request");
  a_ready: assert property (p_ready) else $error("ready low");
  a_err: assert property (p_err) else $error("data on error");
endmodule

// >>> eism_defines.vh
`ifndef EISM_DEFINES_VH
`define EISM_DEFINES_VH

// Register byte offsets on the APB
`define EISM_OFS_SENSE     8'h00
`define EISM_OFS_ENABLE    8'h04
`define EISM_OFS_KEY_LOW   8'h08
`define EISM_OFS_KEY_HIGH  8'h0C
`define EISM_OFS_SYSCTL    8'h10
`define EISM_OFS_STATUS    8'h14

// Reset values
`define EISM_RST_SENSE     8'h00
`define EISM_RST_ENABLE    8'h00
`define EISM_RST_KEY_LOW   8'hBF
`define EISM_RST_KEY_HIGH  8'hFF
`define EISM_RST_SYSCTL    1'b0

// Field positions
`define EISM_SYSCTL_EDGE   0
`define EISM_STATUS_NMI    8

// Vector numbers
`define EISM_VEC_NMI       6'h03
`define EISM_VEC_LINE0     6'h04

// Lines that may wake the device from software standby
`define EISM_WAKE_LINES    8'h47

`endif

// >>> eism_pins.sv
module eism_pins (
  output logic [7:0]  IRQ_PIN_B,
  output logic [15:0] KEY_SENSE_B,
  output logic        NMI_PIN_B
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pins only ever feed the block, never shared with another function
  initial begin
    IRQ_PIN_B = 8'hFF;
    KEY_SENSE_B = 16'hFFFF;
    NMI_PIN_B = 1'b1;
  end
endmodule
